// [hdl/sacr_pkg.sv]
/*
  Constants, field positions, reset values and types for the converter control block.
  Assumes a byte-wide register port with 8-bit register addresses and a single core clock.
*/
// Function
// RL1: Five-bit channel field routes converter positive input
// RL2: Channel register upper three bits read zero
// RL3: Conversion clock is source clock over divider+1
// RL4: Source clock is system clock or burst oscillator
// RL5: Repeat field sums one, four, eight, sixteen conversions
// RL6: Burst mode chains conversions from one start
// RL7: Software keeps right justification when repeating
// RL8: Right-justified high byte holds upper accumulated bits
// RL9: Right-justified low byte holds lower eight bits
// RL10: Left-justified result, low nibble reads zero
// RL11: Enable clear means shutdown, no starts accepted
// RL12: Done flag set on busy fall, sticky
// RL13: Busy reads one while conversion runs
// RL14: Writing busy one starts only in mode zero
// RL15: Window flag set by hardware, cleared by software
// RL16: Start mode selects software, timers or pin
// RL17: Gain word is high byte plus low nibble
// RL18: Extra gain bit adds one sixty-fourth
// RL19: Configuration bit zero enables gain programming
// RL20: Result bytes address and load gain registers
// RL21: Effective gain is word plus sixty-four steps
// RL22: Extra gain bit resets to one
// RL23: Software avoids conversions during gain programming
// RL24: Accumulator clears at each new sequence
package sacr_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_GAIN_HIGH = 8'h04;
  localparam logic [7:0] ADDR_GAIN_LOW = 8'h07;
  localparam logic [7:0] ADDR_GAIN_EXTRA = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL = 8'hBB;
  localparam logic [7:0] ADDR_CONFIG = 8'hBC;
  localparam logic [7:0] ADDR_RES_LOW = 8'hBD;
  localparam logic [7:0] ADDR_RES_HIGH = 8'hBE;
  localparam logic [7:0] ADDR_CONTROL = 8'hE8;

  // ==========================================================
  // Reset values
  localparam logic [4:0] RST_CHANNEL = 5'h1F;
  localparam logic [7:0] RST_CONFIG = 8'hF8;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_GAIN_HIGH = 8'hFC;
  localparam logic [3:0] RST_GAIN_LOW = 4'h0;
  localparam logic RST_GAIN_EXTRA = 1'b1;

  // ==========================================================
  // Field positions
  localparam int CFG_SC_LSB = 3;
  localparam int CFG_RPT_LSB = 1;
  localparam int CFG_GAIN_EN = 0;
  localparam int CTL_EN = 7;
  localparam int CTL_BURST = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_WIN = 3;
  localparam int CTL_LJST = 2;
  localparam int CTL_CM_LSB = 0;
  localparam int GAIN_LOW_LSB = 4;

  // ==========================================================
  // Channel codes, repeat codes, start modes, gain step
  localparam logic [4:0] CH_LAST_PIN = 5'h0F;
  localparam logic [4:0] CH_TEMP = 5'h18;
  localparam logic [4:0] CH_SUPPLY = 5'h19;
  localparam logic [1:0] RPT_1 = 2'h0;
  localparam logic [1:0] RPT_4 = 2'h1;
  localparam logic [1:0] RPT_8 = 2'h2;
  localparam logic [4:0] CNT_1 = 5'h01;
  localparam logic [4:0] CNT_4 = 5'h04;
  localparam logic [4:0] CNT_8 = 5'h08;
  localparam logic [4:0] CNT_16 = 5'h10;
  localparam logic [1:0] CM_SOFTWARE = 2'h0;
  localparam logic [1:0] CM_TIMER1 = 2'h1;
  localparam logic [1:0] CM_EXT_PIN = 2'h2;
  localparam logic [12:0] GAIN_SIXTY_FOURTH = 13'h0040;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CONV = 2'b10
  } sacr_state_t;

  typedef enum logic [3:0] {
    SRC_PIN = 4'b0001,
    SRC_TEMP = 4'b0010,
    SRC_SUPPLY = 4'b0100,
    SRC_GROUND = 4'b1000
  } sacr_src_t;

endpackage

// [hdl/sacr_sar_clk_div.sv]
/*
  Divider that turns source-clock ticks into one-cycle conversion clock ticks.
  Assumes src_tick is synchronous to core_clk; the tick stays high for system clock source.
*/
module sacr_sar_clk_div
  import sacr_pkg::*;
#(
  parameter int DIV_W = 5
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic src_tick,
  input wire logic [DIV_W-1:0] divisor,
  // Divided tick
  output logic sar_tick
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic tick;
  } sacr_div_t;

  sacr_div_t st_r;
  sacr_div_t st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!run)
    begin
      // Restart phase so each conversion started from idle sees whole periods; burst-chained conversions keep the running phase
      st_nxt.cnt = '0;
    end
    else if (src_tick)
    begin
      if (st_r.cnt >= divisor)
      begin
        st_nxt.cnt = '0;
        st_nxt.tick = 1'b1; // see RL3
      end
      else
      begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign sar_tick = st_r.tick;

  // ==========================================================
  // Checks
  a_div_tick_cause: assert property (@(posedge core_clk) disable iff (reset) // see RL3
    sar_tick |-> $past(run) && $past(src_tick) && ($past(st_r.cnt) >= $past(divisor)))
    else $error("conversion clock tick without full divider period");

endmodule

// [hdl/sacr_ctrl.sv]
/*
  Register block and sequencer around a 12-bit successive-approximation converter.
  Assumes the converter core answers each start with one core_done pulse and its data,
  and that the window detector outside reports matches as one-cycle pulses.
*/
module sacr_ctrl
  import sacr_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Start sources
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic external_start_pin,
  // Burst oscillator tick
  input wire logic burst_osc_tick,
  // Converter core
  input wire logic core_done,
  input wire logic [11:0] core_data,
  input wire logic window_match,
  output logic conv_start,
  output logic conversion_clock_tick,
  output logic converter_enable,
  output logic burst_enable,
  // Input multiplexer
  output logic [4:0] channel_field,
  output logic [3:0] mux_source,
  output logic [3:0] mux_pin,
  // Gain
  output logic [11:0] gain_word,
  output logic extra_sixty_fourth_gain,
  output logic [12:0] effective_gain,
  // Flags
  output logic end_of_conversion_irq,
  output logic window_compare_irq
);

  // ==========================================================
  // State
  typedef struct packed {
    sacr_state_t state;
    logic [4:0] ch;
    sacr_src_t src;
    logic [3:0] pin;
    logic [4:0] sc;
    logic [1:0] rpt;
    logic gain_en;
    logic en;
    logic burst;
    logic done;
    logic busy;
    logic win;
    logic ljst;
    logic [1:0] cm;
    logic [7:0] gain_addr;
    logic [7:0] gain_hi;
    logic [3:0] gain_lo;
    logic gain_add;
    logic [12:0] eff_gain;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [15:0] acc;
    logic [4:0] cnt;
    logic conv_start;
    logic ext_prev;
    logic [7:0] rdata;
  } sacr_ctrl_st_t;

  sacr_ctrl_st_t st_r;
  sacr_ctrl_st_t st_nxt;
  sacr_ctrl_st_t st_rst;

  logic sar_tick;
  logic src_tick;
  logic wr_ctl, wr_cfg, wr_ch, wr_lo, wr_hi;
  logic sw_start, trig, seq_end;
  logic [4:0] target;
  logic [4:0] cnt_inc;
  logic [15:0] sum;

  // ==========================================================
  // Conversion clock
  // Burst oscillator is modelled as a tick enable to keep one clock domain
  assign src_tick = st_r.burst ? burst_osc_tick : 1'b1; // see RL4

  sacr_sar_clk_div #(
    .DIV_W(5)
  ) u_div (
    .core_clk(core_clk),
    .reset(reset),
    .run(st_r.state == ST_CONV),
    .src_tick(src_tick),
    .divisor(st_r.sc),
    .sar_tick(sar_tick)
  );

  // ==========================================================
  // Decode
  always_comb
  begin
    wr_ctl = reg_wr && (reg_addr == ADDR_CONTROL);
    wr_cfg = reg_wr && (reg_addr == ADDR_CONFIG);
    wr_ch = reg_wr && (reg_addr == ADDR_CHANNEL);
    wr_lo = reg_wr && (reg_addr == ADDR_RES_LOW);
    wr_hi = reg_wr && (reg_addr == ADDR_RES_HIGH);
    // Writing zero to busy does nothing
    sw_start = wr_ctl && reg_wdata[CTL_BUSY] && (st_r.cm == CM_SOFTWARE); // see RL14
    case (st_r.cm) // see RL16
      CM_SOFTWARE: trig = sw_start;
      CM_TIMER1: trig = timer1_overflow;
      CM_EXT_PIN: trig = external_start_pin && !st_r.ext_prev;
      default: trig = timer2_overflow;
    endcase
    case (st_r.rpt) // see RL5
      RPT_1: target = CNT_1;
      RPT_4: target = CNT_4;
      RPT_8: target = CNT_8;
      default: target = CNT_16;
    endcase
    cnt_inc = st_r.cnt + 5'h01;
    sum = st_r.acc + {4'h0, core_data};
    seq_end = (st_r.state == ST_CONV) && st_r.en && core_done && (cnt_inc == target);
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.conv_start = 1'b0;
    st_nxt.ext_prev = external_start_pin;

    // Register writes
    if (wr_ch)
      st_nxt.ch = reg_wdata[4:0]; // see RL2
    if (wr_cfg)
    begin
      st_nxt.sc = reg_wdata[CFG_SC_LSB +: 5];
      st_nxt.rpt = reg_wdata[CFG_RPT_LSB +: 2];
      st_nxt.gain_en = reg_wdata[CFG_GAIN_EN]; // see RL19
    end
    if (wr_ctl)
    begin
      st_nxt.en = reg_wdata[CTL_EN];
      st_nxt.burst = reg_wdata[CTL_BURST];
      st_nxt.done = reg_wdata[CTL_DONE];
      st_nxt.win = reg_wdata[CTL_WIN]; // see RL15
      st_nxt.ljst = reg_wdata[CTL_LJST];
      st_nxt.cm = reg_wdata[CTL_CM_LSB +: 2];
    end
    // Gain registers are reached only through the result bytes and never read back
    if (st_r.gain_en)
    begin
      if (wr_hi)
        st_nxt.gain_addr = reg_wdata; // see RL20
      if (wr_lo)
        case (st_r.gain_addr) // see RL17
          ADDR_GAIN_HIGH: st_nxt.gain_hi = reg_wdata;
          ADDR_GAIN_LOW: st_nxt.gain_lo = reg_wdata[GAIN_LOW_LSB +: 4];
          ADDR_GAIN_EXTRA: st_nxt.gain_add = reg_wdata[0]; // see RL18
          default: st_nxt.gain_lo = st_r.gain_lo;
        endcase
    end
    else
    begin
      if (wr_hi)
        st_nxt.res_hi = reg_wdata;
      if (wr_lo)
        st_nxt.res_lo = reg_wdata;
    end
    st_nxt.eff_gain = {1'b0, st_r.gain_hi, st_r.gain_lo}
      + (st_r.gain_add ? GAIN_SIXTY_FOURTH : 13'h0000); // see RL21

    // Channel routing; unlisted codes fall to ground
    st_nxt.pin = st_r.ch[3:0];
    if (st_r.ch <= CH_LAST_PIN) // see RL1
      st_nxt.src = SRC_PIN;
    else if (st_r.ch == CH_TEMP)
      st_nxt.src = SRC_TEMP;
    else if (st_r.ch == CH_SUPPLY)
      st_nxt.src = SRC_SUPPLY;
    else
      st_nxt.src = SRC_GROUND;

    // Sequencer
    case (st_r.state)
      ST_IDLE:
      begin
        if (trig && st_r.en) // see RL11
        begin
          if (st_r.cnt == 5'h00)
            st_nxt.acc = 16'h0000; // see RL24
          st_nxt.conv_start = 1'b1;
          st_nxt.busy = 1'b1; // see RL13
          st_nxt.state = ST_CONV;
        end
      end
      ST_CONV:
      begin
        if (!st_r.en)
        begin
          // Disabling aborts the sequence and drops partial sums
          st_nxt.state = ST_IDLE;
          st_nxt.busy = 1'b0;
          st_nxt.cnt = 5'h00;
        end
        else if (core_done)
        begin
          st_nxt.acc = sum;
          if (seq_end)
          begin
            st_nxt.cnt = 5'h00;
            st_nxt.busy = 1'b0;
            st_nxt.state = ST_IDLE;
            if (st_r.ljst)
            begin
              st_nxt.res_hi = sum[11:4]; // see RL10
              st_nxt.res_lo = {sum[3:0], 4'h0};
            end
            else
            begin
              st_nxt.res_hi = sum[15:8]; // see RL8
              st_nxt.res_lo = sum[7:0]; // see RL9
            end
          end
          else if (st_r.burst)
          begin
            st_nxt.cnt = cnt_inc;
            st_nxt.conv_start = 1'b1; // see RL6
          end
          else
          begin
            // Each further conversion waits for its own start
            st_nxt.cnt = cnt_inc;
            st_nxt.busy = 1'b0;
            st_nxt.state = ST_IDLE;
          end
        end
      end
      default:
      begin
        st_nxt.state = ST_IDLE;
        st_nxt.busy = 1'b0;
      end
    endcase

    // Hardware set wins over a software clear in the same cycle
    if (seq_end)
      st_nxt.done = 1'b1; // see RL12
    if (window_match)
      st_nxt.win = 1'b1; // see RL15

    // Read data
    if (reg_rd)
      case (reg_addr)
        ADDR_CHANNEL: st_nxt.rdata = {3'h0, st_r.ch}; // see RL2
        ADDR_CONFIG: st_nxt.rdata = {st_r.sc, st_r.rpt, st_r.gain_en};
        ADDR_RES_LOW: st_nxt.rdata = st_r.res_lo;
        ADDR_RES_HIGH: st_nxt.rdata = st_r.res_hi;
        ADDR_CONTROL: st_nxt.rdata = {st_r.en, st_r.burst, st_r.done, st_r.busy,
                                      st_r.win, st_r.ljst, st_r.cm};
        default: st_nxt.rdata = 8'h00;
      endcase
  end

  // ==========================================================
  // Registers
  always_comb
  begin
    st_rst = '0;
    st_rst.state = ST_IDLE;
    st_rst.ch = RST_CHANNEL;
    st_rst.src = SRC_GROUND;
    st_rst.pin = RST_CHANNEL[3:0];
    st_rst.sc = RST_CONFIG[CFG_SC_LSB +: 5];
    st_rst.rpt = RST_CONFIG[CFG_RPT_LSB +: 2];
    st_rst.gain_en = RST_CONFIG[CFG_GAIN_EN];
    st_rst.cm = RST_CONTROL[CTL_CM_LSB +: 2];
    st_rst.gain_hi = RST_GAIN_HIGH;
    st_rst.gain_lo = RST_GAIN_LOW;
    st_rst.gain_add = RST_GAIN_EXTRA; // see RL22
    st_rst.eff_gain = {1'b0, RST_GAIN_HIGH, RST_GAIN_LOW} + GAIN_SIXTY_FOURTH;
    st_rst.res_hi = RST_RESULT;
    st_rst.res_lo = RST_RESULT;
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
      st_r <= st_rst;
    else
      st_r <= st_nxt;
  end

  assign reg_rdata = st_r.rdata;
  assign conv_start = st_r.conv_start;
  assign conversion_clock_tick = sar_tick;
  assign converter_enable = st_r.en;
  assign burst_enable = st_r.burst;
  assign channel_field = st_r.ch;
  assign mux_source = st_r.src;
  assign mux_pin = st_r.pin;
  assign gain_word = {st_r.gain_hi, st_r.gain_lo};
  assign extra_sixty_fourth_gain = st_r.gain_add;
  assign effective_gain = st_r.eff_gain;
  assign end_of_conversion_irq = st_r.done;
  assign window_compare_irq = st_r.win;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  sequence s_burst_step;
    (st_r.state == ST_CONV) && st_r.en && st_r.burst && core_done && !seq_end;
  endsequence
  sequence s_sw_start;
    (st_r.state == ST_IDLE) && st_r.en && wr_ctl && reg_wdata[CTL_BUSY]
      && (st_r.cm == CM_SOFTWARE);
  endsequence

  a_chan_read_zero: assert property ( // see RL2
    reg_rd && (reg_addr == ADDR_CHANNEL) |=> reg_rdata[7:5] == 3'h0)
    else $error("channel register upper bits not zero");
  a_sw_start_go: assert property ( // see RL14
    s_sw_start |=> conv_start && st_r.busy)
    else $error("software start did not launch conversion");
  a_start_needs_en: assert property ( // see RL11
    !st_r.en |=> !conv_start)
    else $error("conversion started while disabled");
  a_burst_chain_go: assert property ( // see RL6
    s_burst_step |=> conv_start ##1 !conv_start)
    else $error("burst did not chain next conversion");
  a_done_on_fall: assert property ( // see RL12
    $rose(st_r.done) |-> $fell(st_r.busy) || $past(wr_ctl && reg_wdata[CTL_DONE]))
    else $error("done flag rose without busy falling");
  a_done_sticky_hold: assert property ( // see RL12
    st_r.done && !wr_ctl |=> st_r.done)
    else $error("done flag cleared without software");
  a_win_set_hold: assert property ( // see RL15
    window_match |=> (window_compare_irq and (!wr_ctl |=> window_compare_irq)))
    else $error("window flag not set or not sticky");
  a_left_nibble_zero: assert property ( // see RL10
    seq_end && st_r.ljst |=> st_r.res_lo[3:0] == 4'h0 && !st_r.busy)
    else $error("left-justified low nibble not zero");
  a_right_high_byte: assert property ( // see RL8
    seq_end && !st_r.ljst && (st_r.rpt == RPT_1) |=> st_r.res_hi[7:4] == 4'h0)
    else $error("single result high nibble not zero");
  a_gain_low_load: assert property ( // see RL20
    st_r.gain_en && wr_lo && (st_r.gain_addr == ADDR_GAIN_LOW)
      |=> gain_word[3:0] == $past(reg_wdata[7:4]) ##1 effective_gain[3:0] == gain_word[3:0])
    else $error("gain low nibble not loaded");
  a_acc_cleared_new: assert property ( // see RL24
    (st_r.state == ST_IDLE) && trig && st_r.en && (st_r.cnt == 5'h00) |=> st_r.acc == 16'h0000)
    else $error("accumulator not cleared at sequence start");

endmodule

// [verification/sacr_core_model.sv]
/*
  Behavioural converter core that answers the control block's start pulses.
  Assumes one start at a time; ticks_needed sets a prompt or a slow answer.
*/
module sacr_core_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control side
  input wire logic conv_start,
  input wire logic conversion_clock_tick,
  // Behaviour knobs
  input wire logic [7:0] ticks_needed,
  input wire logic [11:0] data_base,
  // Results
  output logic core_done,
  output logic [11:0] core_data
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Conversion timing
  logic busy_r;
  logic [7:0] left_r;
  logic [11:0] n_r;

  // Data toggles outside the done cycle, so a stale value is never mistaken for a result
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      left_r <= 8'h00;
      n_r <= 12'h000;
      core_done <= 1'b0;
      core_data <= 12'h000;
    end
    else
    begin
      core_done <= 1'b0;
      core_data <= ~core_data;
      if (conv_start)
      begin
        busy_r <= 1'b1;
        left_r <= ticks_needed;
      end
      else if (busy_r && conversion_clock_tick)
      begin
        left_r <= left_r - 8'h01;
        if (left_r == 8'h01)
        begin
          busy_r <= 1'b0;
          core_done <= 1'b1;
          core_data <= data_base + n_r;
          n_r <= n_r + 12'h001;
        end
      end
    end
  end
endmodule

// [verification/sacr_ctrl_tb.sv]
/*
  Self-checking bench for the converter control block and a behavioural core.
  Assumes the package and the core model are compiled before this file.
*/
module sacr_ctrl_tb
  import sacr_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic timer1_overflow = 1'b0;
  logic timer2_overflow = 1'b0;
  logic external_start_pin = 1'b0;
  logic burst_osc_tick = 1'b0;
  logic window_match = 1'b0;
  logic [7:0] ticks_needed = 8'h06;
  logic [11:0] data_base = 12'h000;
  logic [7:0] reg_rdata;
  logic core_done, conv_start, conversion_clock_tick, converter_enable, burst_enable;
  logic extra_sixty_fourth_gain, end_of_conversion_irq, window_compare_irq;
  logic [11:0] core_data, gain_word, g;
  logic [3:0] mux_source, mux_pin;
  logic [4:0] channel_field;
  logic [12:0] effective_gain;
  logic [1:0] bdiv = 2'h0;
  logic rd_d = 1'b0;
  logic a;
  logic [7:0] exp_q[$];
  logic [7:0] ctl = 8'h00;
  logic [4:0] sc = 5'h00;
  int nconv = 0;
  int err_count = 0;
  int n_compared = 0;

  sacr_ctrl uut (
    .core_clk, .reset, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .timer1_overflow, .timer2_overflow, .external_start_pin, .burst_osc_tick,
    .core_done, .core_data, .window_match, .conv_start, .conversion_clock_tick,
    .converter_enable, .burst_enable, .channel_field, .mux_source, .mux_pin,
    .gain_word, .extra_sixty_fourth_gain, .effective_gain, .end_of_conversion_irq,
    .window_compare_irq
  );

  sacr_core_model core (
    .core_clk, .reset, .conv_start, .conversion_clock_tick, .ticks_needed, .data_base,
    .core_done, .core_data
  );

  always #5 core_clk = ~core_clk;

  // Burst oscillator runs at a third of the core clock
  always @(posedge core_clk)
  begin
    bdiv <= (bdiv == 2'h2) ? 2'h0 : bdiv + 2'h1;
    burst_osc_tick <= (bdiv == 2'h2);
  end

  // Read data lands one cycle after the strobe
  always @(posedge core_clk)
  begin
    if (rd_d)
      chk(16'(reg_rdata), 16'(exp_q.pop_front()));
    rd_d <= reg_rd;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      err_count++;
      $display("mismatch at %0t ns: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, input logic [7:0] want);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask

  task automatic start(input logic [1:0] m);
    @(posedge core_clk);
    case (m)
      2'h1: timer1_overflow <= 1'b1;
      2'h2: external_start_pin <= 1'b1;
      2'h3: timer2_overflow <= 1'b1;
      default:
      begin
        reg_addr <= ADDR_CONTROL;
        reg_wdata <= ctl | 8'h10;
        reg_wr <= 1'b1;
      end
    endcase
    @(posedge core_clk);
    {timer1_overflow, timer2_overflow, external_start_pin, reg_wr} <= 4'h0;
  endtask

  task automatic wait_done;
    int c;
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (core_done !== 1'b1 && c < 1000);
    if (c >= 1000)
    begin
      err_count++;
      print_verdict;
    end
  endtask

  task automatic no_start;
    int c;
    c = 0;
    repeat (8)
    begin
      @(posedge core_clk);
      if (conv_start !== 1'b0)
        c++;
    end
    chk(16'(c), 16'h0000);
  endtask

  // Cycles between two conversion clock ticks
  task automatic measure(input int want);
    int c;
    c = 0;
    while (conversion_clock_tick !== 1'b1 && c < 2000)
    begin
      @(posedge core_clk);
      c++;
    end
    c = 0;
    do
    begin
      @(posedge core_clk);
      c++;
    end
    while (conversion_clock_tick !== 1'b1 && c < 2000);
    chk(16'(c), 16'(want));
  endtask

  task automatic run_seq(input logic [1:0] m, input logic [1:0] rpt, input logic lj,
                         input logic bu);
    int n;
    logic [15:0] sum;
    logic [11:0] d;
    n = rpt == RPT_1 ? CNT_1 : rpt == RPT_4 ? CNT_4 : rpt == RPT_8 ? CNT_8 : CNT_16;
    sum = 16'h0000;
    wr(ADDR_CONFIG, {sc, rpt, 1'b0});
    rd(ADDR_CONFIG, {sc, rpt, 1'b0});
    ctl = {1'b1, bu, 3'b000, lj, m};
    wr(ADDR_CONTROL, ctl);
    @(posedge core_clk);
    chk(16'(burst_enable), 16'(bu));
    for (int i = 0; i < n; i++)
    begin
      d = data_base + nconv[11:0];
      sum = sum + 16'(d);
      nconv++;
      if (i == 0 || !bu)
        start(m);
      if (i == 0 && ticks_needed > 8'h03)
      begin
        rd(ADDR_CONTROL, ctl | 8'h10);
        measure(bu ? (int'(sc) + 1) * 3 : int'(sc) + 1);
      end
      wait_done;
    end
    rd(ADDR_CONTROL, ctl | 8'h20);
    rd(ADDR_RES_HIGH, lj ? sum[11:4] : sum[15:8]);
    rd(ADDR_RES_LOW, lj ? {sum[3:0], 4'h0} : sum[7:0]);
    chk(16'(end_of_conversion_irq), 16'h0001);
    wr(ADDR_CONTROL, ctl);
    rd(ADDR_CONTROL, ctl);
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(60630));
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_CONFIG, RST_CONFIG);
    rd(ADDR_CONTROL, RST_CONTROL);
    rd(ADDR_RES_HIGH, RST_RESULT);
    rd(8'h55, 8'h00);
    chk(16'(extra_sixty_fourth_gain), 16'(RST_GAIN_EXTRA));
    chk(16'(effective_gain), 16'({RST_GAIN_HIGH, RST_GAIN_LOW}) + 16'h0040);
    for (int i = 0; i < 32; i++)
    begin
      wr(ADDR_CHANNEL, {3'($urandom), 5'(i)});
      rd(ADDR_CHANNEL, {3'h0, 5'(i)});
      @(posedge core_clk);
      chk(16'(channel_field), 16'(i));
      chk(16'(mux_source), 16'(i < 16 ? SRC_PIN : i == 24 ? SRC_TEMP :
          i == 25 ? SRC_SUPPLY : SRC_GROUND));
      if (i < 16)
        chk(16'(mux_pin), 16'(i));
    end
    // No conversion runs while gain programming is on
    g = 12'($urandom);
    a = 1'($urandom);
    wr(ADDR_CONFIG, 8'h01);
    wr(ADDR_RES_HIGH, ADDR_GAIN_HIGH);
    wr(ADDR_RES_LOW, g[11:4]);
    wr(ADDR_RES_HIGH, ADDR_GAIN_LOW);
    wr(ADDR_RES_LOW, {g[3:0], 4'h0});
    wr(ADDR_RES_HIGH, ADDR_GAIN_EXTRA);
    wr(ADDR_RES_LOW, {7'h00, a});
    wr(ADDR_CONFIG, 8'h00);
    rd(ADDR_RES_LOW, RST_RESULT);
    chk(16'(gain_word), 16'(g));
    chk(16'(extra_sixty_fourth_gain), 16'(a));
    chk(16'(effective_gain), 16'(g) + (a ? 16'h0040 : 16'h0000));
    data_base <= 12'($urandom);
    sc = 5'($urandom);
    for (int r = 0; r < 4; r++)
      run_seq(CM_SOFTWARE, 2'(r), 1'b0, 1'b0);
    // Left format only with single conversions
    run_seq(CM_SOFTWARE, RPT_1, 1'b1, 1'b0);
    for (int m = 1; m < 4; m++)
      run_seq(2'(m), RPT_4, 1'b0, 1'b0);
    run_seq(CM_TIMER1, 2'h3, 1'b0, 1'b1);
    ticks_needed <= 8'h01;
    run_seq(CM_EXT_PIN, RPT_8, 1'b0, 1'b1);
    @(posedge core_clk);
    window_match <= 1'b1;
    @(posedge core_clk);
    window_match <= 1'b0;
    repeat (20) @(posedge core_clk);
    rd(ADDR_CONTROL, ctl | 8'h08);
    chk(16'(window_compare_irq), 16'h0001);
    wr(ADDR_CONTROL, ctl);
    rd(ADDR_CONTROL, ctl);
    ctl = 8'h81;
    wr(ADDR_CONTROL, ctl);
    start(CM_SOFTWARE);
    no_start;
    start(2'h3);
    no_start;
    ctl = 8'h00;
    wr(ADDR_CONTROL, ctl);
    start(CM_SOFTWARE);
    no_start;
    chk(16'(converter_enable), 16'h0000);
    repeat (2) @(posedge core_clk);
    print_verdict;
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (90000) @(posedge core_clk);
    err_count++;
    print_verdict;
  end
endmodule
